// file: src/abn_encoder_pkg.sv
// Purpose: Shared constants for the ABN encoder interface.
// Assumes: Word-wide register port with a 7-bit register address.
// Notes:   Offsets are register addresses on the host register port.
package abn_encoder_pkg;

    // Register port geometry.
    localparam int          ADDR_W = 7;
    localparam int          DATA_W = 32;

    // Register addresses.
    localparam logic [6:0]  ADDR_CONFIG    = 7'h38;
    localparam logic [6:0]  ADDR_POSITION  = 7'h39;
    localparam logic [6:0]  ADDR_STEP      = 7'h3A;
    localparam logic [6:0]  ADDR_STATUS    = 7'h3B;
    localparam logic [6:0]  ADDR_LATCHED   = 7'h3C;
    localparam logic [6:0]  ADDR_DEV_LIMIT = 7'h3D;

    // Configuration field positions.
    localparam int          CFG_W           = 11;
    localparam int          CFG_POL_A       = 0;
    localparam int          CFG_POL_B       = 1;
    localparam int          CFG_POL_N       = 2;
    localparam int          CFG_SKIP_QUAL   = 3;
    localparam int          CFG_LATCH_CONT  = 4;
    localparam int          CFG_LATCH_ONCE  = 5;
    localparam int          CFG_EDGE_POS    = 6;
    localparam int          CFG_EDGE_NEG    = 7;
    localparam int          CFG_CLEAR_POS   = 8;
    localparam int          CFG_LATCH_RAMP  = 9;
    localparam int          CFG_DECIMAL     = 10;

    // Status field positions.
    localparam int          STAT_INDEX      = 0;
    localparam int          STAT_DEVIATION  = 1;

    // Widths.
    localparam int          DEV_W           = 20;
    localparam int          FRAC_W          = 16;

    // Values after reset.
    localparam logic [10:0] CONFIG_RESET    = 11'h000;
    localparam logic [31:0] POSITION_RESET  = 32'h0000_0000;
    localparam logic [31:0] STEP_RESET      = 32'h0001_0000;
    localparam logic [19:0] DEV_RESET       = 20'h00000;

    // Fraction moduli for binary and decimal prescaling.
    localparam logic [16:0] FRAC_MOD_BIN    = 17'h10000;
    localparam logic [16:0] FRAC_MOD_DEC    = 17'h02710;

endpackage

// file: src/quadrature_decoder.sv
// Purpose: Synchronise A, B and N pins and decode quadrature steps.
// Assumes: Pins are asynchronous to sys_clk and change slower than the clock.
// Notes:   A step where both A and B changed at once is dropped.
`timescale 1ns/1ns
module quadrature_decoder
    import abn_encoder_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic enc_a,
    input  wire logic enc_b,
    input  wire logic enc_n,
    output logic      a_sync,
    output logic      b_sync,
    output logic      n_sync,
    output logic      step_q,
    output logic      up_q
);

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [1:0] prev_q;
    logic [2:0] warm_q;

    // Two-stage synchroniser; the first stage feeds only the second.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end
        else
        begin
            meta_q <= {enc_n, enc_b, enc_a};
            sync_q <= meta_q;
        end
    end

    assign a_sync = sync_q[0];
    assign b_sync = sync_q[1];
    assign n_sync = sync_q[2];

    // One step per single-line change; direction is up when A leads B.
    // The warm-up bits mask the first three compares, whose values still come at least partly from the reset state.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_q <= 2'h0;
            warm_q <= 3'h0;
            step_q <= 1'b0;
            up_q   <= 1'b0;
        end
        else
        begin
            prev_q <= sync_q[1:0];
            warm_q <= {warm_q[1:0], 1'b1};
            step_q <= warm_q[2] && (^(sync_q[1:0] ^ prev_q));
            up_q   <= sync_q[0] ^ prev_q[1];
        end
    end

endmodule // quadrature_decoder

// file: src/abn_encoder_interface.sv
// Purpose: ABN encoder position counter with index latch and deviation check.
// Assumes: Register port on sys_clk; ramp position comes from sys_clk logic.
// Notes:   Read data appears one cycle after the address is presented.
//
// Functional notes
// - Encoder position is a signed 32-bit count, readable and writable.
// - Step constant is signed 32-bit: 16 integer bits, 16 fraction bits.
// - Each decoded step adds or subtracts the constant, fraction over 2^16 or 10^4.
// - Config bit 10 selects fraction units of 1/65536 or 1/10000.
// - Status bit 0 index event, bit 1 deviation; write 1 clears.
// - Deviation flag cannot be cleared while the deviation persists.
// - Both status flags are ORed onto the interrupt output.
// - Armed index event copies position into read-only latched register.
// - Deviation flag sets when position difference exceeds nonzero 20-bit limit.
// - Config bit 9 also latches ramp actual position on latching events.
// - Config bit 8 clears position after latching on index event.
// - Config bits 7:6 pick level, active edge, inactive edge or both.
// - Config bit 5 latches only on first index event after the write.
// - Config bit 4 latches on every index event.
// - Config bit 3 clear requires A and B polarity match; set ignores them.
// - Config bit 2 sets index polarity: 0 low active, 1 high active.
`timescale 1ns/1ns
module abn_encoder_interface
    import abn_encoder_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              enc_a,
    input  wire logic              enc_b,
    input  wire logic              enc_n,
    input  wire logic [31:0]       ramp_actual_position,
    input  wire logic              reg_wr,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0]      reg_rdata,
    output logic                   enc_irq,
    output logic [31:0]            ramp_latched_position
);

    logic              a_s;
    logic              b_s;
    logic              n_s;
    logic              step;
    logic              up;
    logic [CFG_W-1:0]  cfg_q;
    logic [31:0]       pos_q;
    logic [15:0]       rem_q;
    logic [31:0]       step_q;
    logic [DEV_W-1:0]  limit_q;
    logic [31:0]       latch_q;
    logic [31:0]       ramp_latch_q;
    logic              n_evt_q;
    logic              dev_q;
    logic              once_q;
    logic              qual_q;
    logic [1:0]        warm_q;
    logic              irq_q;
    logic [31:0]       rdata_q;
    logic              wr_cfg;
    logic              wr_pos;
    logic              wr_step;
    logic              wr_stat;
    logic              wr_lim;
    logic              qual;
    logic              index_evt;
    logic              latch_go;
    logic              dev_cond;
    logic [31:0]       pos_d;
    logic [16:0]       rem_d;
    logic [16:0]       modulus;
    logic [16:0]       frac;
    logic [16:0]       rem_w;
    logic [16:0]       sum;
    logic [31:0]       int_part;
    logic [32:0]       diff;
    logic [32:0]       mag;

    quadrature_decoder u_decoder
    (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .enc_a   (enc_a),
        .enc_b   (enc_b),
        .enc_n   (enc_n),
        .a_sync  (a_s),
        .b_sync  (b_s),
        .n_sync  (n_s),
        .step_q  (step),
        .up_q    (up)
    );

    // Write strobes decoded per register.
    assign wr_cfg  = reg_wr && (reg_addr == ADDR_CONFIG);
    assign wr_pos  = reg_wr && (reg_addr == ADDR_POSITION);
    assign wr_step = reg_wr && (reg_addr == ADDR_STEP);
    assign wr_stat = reg_wr && (reg_addr == ADDR_STATUS);
    assign wr_lim  = reg_wr && (reg_addr == ADDR_DEV_LIMIT);

    // Index qualification on N polarity and, unless skipped, A and B levels.
    // Held off until the synchroniser carries real pin levels, so reset gives no false event.
    assign qual = warm_q[1] && (n_s == cfg_q[CFG_POL_N]) &&
                  (cfg_q[CFG_SKIP_QUAL] ||
                   ((a_s == cfg_q[CFG_POL_A]) &&
                    (b_s == cfg_q[CFG_POL_B])));

    // Sensitivity selection: level, active edge, inactive edge or both.
    always_comb
    begin
        case (cfg_q[CFG_EDGE_NEG:CFG_EDGE_POS])
            2'b00:   index_evt = qual;
            2'b01:   index_evt = qual && !qual_q;
            2'b10:   index_evt = !qual && qual_q;
            default: index_evt = qual ^ qual_q;
        endcase
    end

    // Latching is armed continuously or once after a configuration write.
    assign latch_go = index_evt && (cfg_q[CFG_LATCH_CONT] || once_q);

    // Previous qualified level for edge detection, and the synchroniser warm-up.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            qual_q <= 1'b0;
            warm_q <= 2'h0;
        end
        else
        begin
            qual_q <= qual;
            warm_q <= {warm_q[0], 1'b1};
        end
    end

    // Configuration register; a write with bit 5 set arms a single latch.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q  <= CONFIG_RESET;
            once_q <= 1'b0;
        end
        else if (wr_cfg)
        begin
            cfg_q  <= reg_wdata[CFG_W-1:0];
            once_q <= reg_wdata[CFG_LATCH_ONCE];
        end
        else if (latch_go)
            once_q <= 1'b0;
    end

    // Step constant and deviation limit, both write-only.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            step_q  <= STEP_RESET;
            limit_q <= DEV_RESET;
        end
        else
        begin
            if (wr_step)
                step_q <= reg_wdata;
            if (wr_lim)
                limit_q <= reg_wdata[DEV_W-1:0];
        end
    end

    // Fixed-point accumulation with a modulus chosen by the prescaler mode.
    assign modulus  = cfg_q[CFG_DECIMAL] ? FRAC_MOD_DEC : FRAC_MOD_BIN;
    assign frac     = {1'b0, step_q[FRAC_W-1:0]};
    assign int_part = {{16{step_q[31]}}, step_q[31:16]};
    assign rem_w    = {1'b0, rem_q};
    assign sum      = rem_w + frac;

    always_comb
    begin
        if (up)
        begin
            if (sum >= modulus)
            begin
                rem_d = sum - modulus;
                pos_d = pos_q + int_part + 32'h0000_0001;
            end
            else
            begin
                rem_d = sum;
                pos_d = pos_q + int_part;
            end
        end
        else
        begin
            if (rem_w >= frac)
            begin
                rem_d = rem_w - frac;
                pos_d = pos_q - int_part;
            end
            else
            begin
                rem_d = rem_w + modulus - frac;
                pos_d = pos_q - int_part - 32'h0000_0001;
            end
        end
    end

    // Position counter: software write wins, then index clear, then steps.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pos_q <= POSITION_RESET;
            rem_q <= 16'h0000;
        end
        else if (wr_pos)
        begin
            pos_q <= reg_wdata;
            rem_q <= 16'h0000;
        end
        else if (latch_go && cfg_q[CFG_CLEAR_POS])
        begin
            pos_q <= POSITION_RESET;
            rem_q <= 16'h0000;
        end
        else if (step)
        begin
            pos_q <= pos_d;
            rem_q <= rem_d[FRAC_W-1:0];
        end
    end

    // Index latches of encoder and, optionally, ramp position.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_q      <= POSITION_RESET;
            ramp_latch_q <= POSITION_RESET;
        end
        else if (latch_go)
        begin
            latch_q <= pos_q;
            if (cfg_q[CFG_LATCH_RAMP])
                ramp_latch_q <= ramp_actual_position;
        end
    end

    // Deviation magnitude against a nonzero limit.
    assign diff     = {pos_q[31], pos_q} - {ramp_actual_position[31], ramp_actual_position};
    assign mag      = diff[32] ? (33'h0 - diff) : diff;
    assign dev_cond = (limit_q != DEV_RESET) &&
                      (mag > {13'h0000, limit_q});

    // Sticky status flags; a new event wins over a same-cycle clear.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            n_evt_q <= 1'b0;
            dev_q   <= 1'b0;
        end
        else
        begin
            if (index_evt)
                n_evt_q <= 1'b1;
            else if (wr_stat && reg_wdata[STAT_INDEX])
                n_evt_q <= 1'b0;
            if (dev_cond)
                dev_q <= 1'b1;
            else if (wr_stat && reg_wdata[STAT_DEVIATION])
                dev_q <= 1'b0;
        end
    end

    // Interrupt is the OR of both status flags.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            irq_q <= 1'b0;
        else
            irq_q <= n_evt_q || dev_q;
    end

    // Registered read mux; write-only and unmapped addresses read zero.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= 32'h0000_0000;
        else
        begin
            case (reg_addr)
                ADDR_CONFIG:   rdata_q <= {21'h000000, cfg_q};
                ADDR_POSITION: rdata_q <= pos_q;
                ADDR_STATUS:   rdata_q <= {30'h00000000, dev_q, n_evt_q};
                ADDR_LATCHED:  rdata_q <= latch_q;
                default:       rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign reg_rdata             = rdata_q;
    assign enc_irq               = irq_q;
    assign ramp_latched_position = ramp_latch_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_pos_write;
        wr_pos |=> (pos_q == $past(reg_wdata));
    endproperty
    a_pos_write: assert property (p_pos_write) else $error("position write lost");

    property p_bin_step;
        (step && !wr_pos && !latch_go && !cfg_q[CFG_DECIMAL] && up)
        |=> ({pos_q, rem_q} == $past({pos_q, rem_q}) + {{16{$past(step_q[31])}}, $past(step_q)});
    endproperty
    a_bin_step: assert property (p_bin_step) else $error("binary step sum wrong");

    property p_index_clear;
        (wr_stat && reg_wdata[STAT_INDEX] && !index_evt) |=> !n_evt_q;
    endproperty
    a_index_clear: assert property (p_index_clear) else $error("index flag not cleared");

    property p_dev_hold;
        (dev_cond && wr_stat && reg_wdata[STAT_DEVIATION]) |=> dev_q;
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("deviation flag cleared early");

    property p_irq;
        ##1 (enc_irq == ($past(n_evt_q) || $past(dev_q)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not OR of flags");

    property p_latch;
        latch_go |=> (latch_q == $past(pos_q));
    endproperty
    a_latch: assert property (p_latch) else $error("position not latched");

    property p_dev_off;
        (limit_q == DEV_RESET) |-> !dev_cond;
    endproperty
    a_dev_off: assert property (p_dev_off) else $error("deviation with zero limit");

    property p_ramp_latch;
        (latch_go && cfg_q[CFG_LATCH_RAMP]) |=> (ramp_latched_position == $past(ramp_actual_position));
    endproperty
    a_ramp_latch: assert property (p_ramp_latch) else $error("ramp not latched");

    property p_clear;
        (latch_go && cfg_q[CFG_CLEAR_POS] && !wr_pos) |=> (pos_q == POSITION_RESET);
    endproperty
    a_clear: assert property (p_clear) else $error("position not cleared");

    property p_once;
        (latch_go && !wr_cfg) |=> !once_q;
    endproperty
    a_once: assert property (p_once) else $error("single latch stays armed");

endmodule // abn_encoder_interface

// file: dv/quad_encoder_model.sv
// Purpose: Behavioural incremental encoder with A, B and index lines.
// Assumes: Requests arrive one cycle wide, spaced well apart by the bench.
// Notes:   The double request moves both A and B at once on purpose.
`timescale 1ns/1ns
module quad_encoder_model
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic step_req,
    input  wire logic step_up,
    input  wire logic dbl_req,
    input  wire logic index_lvl,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_n
);
    logic [1:0] phase_q;

    // Phase walks 00, 10, 11, 01 when turning up, so A leads B.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            phase_q <= 2'h0;
        else if (step_req)
            phase_q <= step_up ? phase_q + 2'h1 : phase_q - 2'h1;
        else if (dbl_req)
            phase_q <= phase_q + 2'h2; // Both lines change together.
    end

    // Gray outputs from the phase, index follows the bench level.
    assign enc_a = (phase_q == 2'h1) || (phase_q == 2'h2);
    assign enc_b = (phase_q == 2'h2) || (phase_q == 2'h3);
    assign enc_n = index_lvl;
endmodule // quad_encoder_model

// file: dv/abn_encoder_interface_tb_top.sv
// Purpose: Self-checking bench for the ABN encoder interface.
// Assumes: Index line idles high and is used low active throughout.
// Notes:   Reads wait two edges so the registered read data has settled.
`timescale 1ns/1ns
module abn_encoder_interface_tb_top;
    import abn_encoder_pkg::*;

    typedef struct {logic [31:0] k; logic dec; int up; int dn; logic [31:0] pos;} row_t;

    logic        sys_clk, resetn, reg_wr, step_req, step_up, dbl_req, index_lvl;
    logic        enc_a, enc_b, enc_n, enc_irq;
    logic [6:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ramp_actual_position, ramp_latched_position, v;
    int          n_mismatch, samples_checked;
    row_t        rows [5];

    quad_encoder_model i_quad_encoder_model (.sys_clk(sys_clk), .resetn(resetn), .step_req(step_req),
        .step_up(step_up), .dbl_req(dbl_req), .index_lvl(index_lvl), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));

    abn_encoder_interface i_abn_encoder_interface (.sys_clk(sys_clk), .resetn(resetn), .enc_a(enc_a),
        .enc_b(enc_b), .enc_n(enc_n), .ramp_actual_position(ramp_actual_position), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enc_irq(enc_irq),
        .ramp_latched_position(ramp_latched_position));

    // Free running clock at 100 MHz.
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        repeat (2) @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask

    task automatic step(input logic up);
        @(posedge sys_clk);
        #1;
        step_req = 1'b1;
        step_up = up;
        @(posedge sys_clk);
        #1;
        step_req = 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic npulse();
        index_lvl = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        index_lvl = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask

    // Cuts a hung run short.
    initial
    begin
        #500000;
        n_mismatch++;
        give_verdict();
    end

    // Main sequence: reset, table rows, then hand-written cases.
    initial
    begin
        {reg_wr, step_req, step_up, dbl_req} = 4'h0;
        index_lvl = 1'b1;
        reg_addr = 7'h00;
        reg_wdata = 32'h0000_0000;
        ramp_actual_position = 32'h0000_0000;
        n_mismatch = 0;
        samples_checked = 0;
        rows[0] = '{32'h0001_0000, 1'b0, 3, 0, 32'h0000_0003};
        rows[1] = '{32'h0000_8000, 1'b0, 3, 0, 32'h0000_0001};
        rows[2] = '{32'h0001_1388, 1'b1, 3, 0, 32'h0000_0004};
        rows[3] = '{32'h0002_0000, 1'b0, 1, 3, 32'hFFFF_FFFC};
        rows[4] = '{32'hFFFF_0000, 1'b0, 2, 0, 32'hFFFF_FFFE};
        resetn = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        chk("irq", enc_irq, 32'h0);
        chk("ramp latch", ramp_latched_position, 32'h0);
        foreach (rows[i]) // Every mapped address and one unmapped read zero.
        begin
            rd(7'h38 + 7'(i), v);
            chk("reset reg", v, 32'h0);
        end
        rd(ADDR_DEV_LIMIT, v);
        chk("limit", v, 32'h0);
        rd(7'h10, v);
        chk("unmapped", v, 32'h0);
        wr(ADDR_LATCHED, 32'h1234_5678);
        rd(ADDR_LATCHED, v);
        chk("latched ro", v, 32'h0);
        step(1'b1);
        rd(ADDR_POSITION, v);
        chk("default step", v, 32'h1);
        // Ordinary accumulation cases.
        foreach (rows[i])
        begin
            wr(ADDR_STEP, rows[i].k);
            wr(ADDR_CONFIG, 32'(rows[i].dec) << CFG_DECIMAL);
            wr(ADDR_POSITION, 32'h0);
            repeat (rows[i].up) step(1'b1);
            repeat (rows[i].dn) step(1'b0);
            rd(ADDR_POSITION, v);
            chk("row pos", v, rows[i].pos);
        end
        wr(ADDR_STEP, 32'h0001_0000);
        wr(ADDR_POSITION, 32'h0);
        @(posedge sys_clk);
        #1;
        dbl_req = 1'b1;
        @(posedge sys_clk);
        #1;
        dbl_req = 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(ADDR_POSITION, v);
        chk("double", v, 32'h0);
        // Continuous latch with clear and ramp latch on active-going edge.
        ramp_actual_position = 32'h0000_0123;
        wr(ADDR_CONFIG, 32'h0358);
        rd(ADDR_CONFIG, v);
        chk("config rb", v, 32'h358);
        wr(ADDR_POSITION, 32'h5);
        npulse();
        rd(ADDR_LATCHED, v);
        chk("latch", v, 32'h5);
        rd(ADDR_POSITION, v);
        chk("cleared", v, 32'h0);
        chk("ramp latch", ramp_latched_position, 32'h123);
        rd(ADDR_STATUS, v);
        chk("flag", v, 32'h1);
        chk("irq", enc_irq, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        rd(ADDR_STATUS, v);
        chk("flag clr", v, 32'h0);
        chk("irq clr", enc_irq, 32'h0);
        // Single latch after the config write; ramp latch is off here.
        ramp_actual_position = 32'h0000_0456;
        wr(ADDR_CONFIG, 32'h0068);
        wr(ADDR_POSITION, 32'h7);
        npulse();
        rd(ADDR_POSITION, v);
        chk("no clear", v, 32'h7);
        chk("ramp hold", ramp_latched_position, 32'h123);
        wr(ADDR_POSITION, 32'h9);
        npulse();
        rd(ADDR_LATCHED, v);
        chk("once", v, 32'h7);
        // Inactive-going edge only.
        wr(ADDR_CONFIG, 32'h0098);
        wr(ADDR_POSITION, 32'hB);
        index_lvl = 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(ADDR_LATCHED, v);
        chk("neg early", v, 32'h7);
        index_lvl = 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(ADDR_LATCHED, v);
        chk("neg edge", v, 32'hB);
        // A and B qualification against the present pin levels.
        wr(ADDR_STATUS, 32'h3);
        wr(ADDR_CONFIG, 32'h0050 | 32'({~enc_b, ~enc_a}));
        wr(ADDR_POSITION, 32'hD);
        npulse();
        rd(ADDR_LATCHED, v);
        chk("unqual", v, 32'hB);
        rd(ADDR_STATUS, v);
        chk("unqual flag", v, 32'h0);
        wr(ADDR_CONFIG, 32'h0050 | 32'({enc_b, enc_a}));
        npulse();
        rd(ADDR_LATCHED, v);
        chk("qual", v, 32'hD);
        // Deviation at and beyond the limit; position is set before the limit arms the check.
        wr(ADDR_CONFIG, 32'h0);
        wr(ADDR_STATUS, 32'h3);
        ramp_actual_position = 32'h0;
        wr(ADDR_POSITION, 32'h4);
        wr(ADDR_DEV_LIMIT, 32'h4);
        rd(ADDR_STATUS, v);
        chk("dev edge", v[1], 1'b0);
        wr(ADDR_POSITION, 32'h5);
        rd(ADDR_STATUS, v);
        chk("dev set", v[1], 1'b1);
        chk("dev irq", enc_irq, 32'h1);
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, v);
        chk("dev hold", v[1], 1'b1);
        ramp_actual_position = 32'h5;
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, v);
        chk("dev clr", v[1], 1'b0);
        wr(ADDR_DEV_LIMIT, 32'h0);
        wr(ADDR_POSITION, 32'h100);
        rd(ADDR_STATUS, v);
        chk("dev off", v[1], 1'b0);
        give_verdict();
    end
endmodule // abn_encoder_interface_tb_top
